// >>> design/wfs_top.sv
/*
 * weighing post-processor: bridge ratio scaling, filter selection, dynamic
 * IIR level control, gain and tare, steady-state detection.
 * assumes samples and parameter writes arrive on clk from on-chip logic.
 */
`timescale 1ns/1ns
module wfs_top #(
	parameter int MS_CYCLES  = wfs_pkg::MS_CYCLES_DOC,
	parameter int FIR50_TAPS = wfs_pkg::FIR50_TAPS_DEF,
	parameter int FIR60_TAPS = wfs_pkg::FIR60_TAPS_DEF,
	parameter int FIR_DEPTH  = 32
) (
	input  wire logic               clk,
	input  wire logic               rst_b,
	input  wire logic               param_wr,
	input  wire logic [7:0]         param_idx,
	input  wire logic [15:0]        param_data,
	input  wire logic               sample_valid,
	input  wire logic signed [23:0] bridge_signal_voltage,
	input  wire logic signed [23:0] bridge_sense_voltage,
	output logic signed [31:0]      weight_q,
	output logic                    weight_valid_q,
	output logic [15:0]             weigh_status_word_q,
	output logic [3:0]              iir_level_q,
	output logic                    busy_q
);
	import wfs_pkg::*;

	localparam int NUM_W = 82;
	localparam int DIF_W = 50;
	localparam int DEN_W = 40;
	localparam int CNT_W = $clog2(NUM_W + 1);
	localparam int MS_W  = $clog2(MS_CYCLES + 1);
	localparam int PTR_W = $clog2(FIR_DEPTH);
	localparam logic [RECIP_BITS:0] RECIP50 = (RECIP_BITS+1)'((1 << RECIP_BITS) / FIR50_TAPS);
	localparam logic [RECIP_BITS:0] RECIP60 = (RECIP_BITS+1)'((1 << RECIP_BITS) / FIR60_TAPS);

	// ======================================================================
	// parameter store
	logic [7:0]  filter_select_q;
	logic [15:0] dyn_filter_period_q;
	logic [15:0] dyn_filter_limit_q;
	logic [15:0] bridge_sensitivity_q;
	logic [15:0] bridge_zero_offset_q;
	logic [15:0] user_gain_q;
	logic [15:0] user_tare_q;
	logic [15:0] transducer_full_load_q;
	logic [15:0] load_scaling_q;
	logic [15:0] settle_tolerance_q;
	logic [15:0] settle_time_q;
	logic        fsel_wr_q;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			filter_select_q        <= RST_FILTER_SELECT;
			dyn_filter_period_q    <= RST_DYN_PERIOD;
			dyn_filter_limit_q     <= RST_DYN_LIMIT;
			bridge_sensitivity_q   <= RST_SENSITIVITY;
			bridge_zero_offset_q   <= RST_ZERO_OFFSET;
			user_gain_q            <= RST_USER_GAIN;
			user_tare_q            <= RST_USER_TARE;
			transducer_full_load_q <= RST_FULL_LOAD;
			load_scaling_q         <= RST_LOAD_SCALING;
			settle_tolerance_q     <= RST_SETTLE_TOL;
			settle_time_q          <= RST_SETTLE_TIME;
			fsel_wr_q              <= 1'b0;
		end else begin
			fsel_wr_q <= param_wr && (param_idx == IDX_FILTER_SELECT);
			if (param_wr) begin
				if (param_idx == IDX_FILTER_SELECT) begin
					filter_select_q <= param_data[7:0];
				end else if (param_idx == IDX_DYN_PERIOD) begin
					dyn_filter_period_q <= param_data;
				end else if (param_idx == IDX_DYN_LIMIT) begin
					dyn_filter_limit_q <= param_data;
				end else if (param_idx == IDX_SENSITIVITY) begin
					bridge_sensitivity_q <= param_data;
				end else if (param_idx == IDX_ZERO_OFFSET) begin
					bridge_zero_offset_q <= param_data;
				end else if (param_idx == IDX_USER_GAIN) begin
					user_gain_q <= param_data;
				end else if (param_idx == IDX_USER_TARE) begin
					user_tare_q <= param_data;
				end else if (param_idx == IDX_FULL_LOAD) begin
					transducer_full_load_q <= param_data;
				end else if (param_idx == IDX_LOAD_SCALING) begin
					load_scaling_q <= param_data;
				end else if (param_idx == IDX_SETTLE_TOL) begin
					settle_tolerance_q <= param_data;
				end else if (param_idx == IDX_SETTLE_TIME) begin
					settle_time_q <= param_data;
				end
			end
		end
	end

	// ======================================================================
	// scaling: |sig*1e7 - zb*sen| * nl * sf / (|sen| * ro), one serial divide
	logic signed [DIF_W-1:0] diff_w;
	logic [DIF_W-1:0]        diff_mag_w;
	logic [23:0]             sen_mag_w;
	logic [NUM_W-1:0]        num_w;
	logic [DEN_W-1:0]        den_w;

	always_comb begin
		diff_w = DIF_W'($signed(bridge_signal_voltage) * $signed(DIF_W'(RATIO_E7)))
			- DIF_W'($signed({1'b0, bridge_zero_offset_q}) * $signed(bridge_sense_voltage));
		diff_mag_w = diff_w[DIF_W-1] ? DIF_W'(-diff_w) : DIF_W'(diff_w);
		sen_mag_w  = bridge_sense_voltage[23] ? 24'(-bridge_sense_voltage)
			: 24'(bridge_sense_voltage);
		num_w = NUM_W'(diff_mag_w) * NUM_W'(transducer_full_load_q)
			* NUM_W'(load_scaling_q);
		den_w = DEN_W'(sen_mag_w) * DEN_W'(bridge_sensitivity_q);
	end

	wfs_state_t         state_q;
	logic [NUM_W-1:0]   num_q;
	logic [DEN_W-1:0]   den_q;
	logic [DEN_W-1:0]   rem_q;
	logic [CNT_W-1:0]   bit_cnt_q;
	logic               neg_q;
	logic signed [31:0] abs_val_q;
	logic [DEN_W:0]     rem_sh_w;

	assign rem_sh_w = {rem_q, num_q[NUM_W-1]};

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q   <= ST_IDLE;
			num_q     <= '0;
			den_q     <= '0;
			rem_q     <= '0;
			bit_cnt_q <= '0;
			neg_q     <= 1'b0;
			abs_val_q <= 32'sh0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					// zero excitation or sensitivity gives no ratio; drop the sample
					if (sample_valid && den_w != '0) begin
						num_q     <= num_w;
						den_q     <= den_w;
						rem_q     <= '0;
						bit_cnt_q <= CNT_W'(NUM_W);
						neg_q     <= diff_w[DIF_W-1] ^ bridge_sense_voltage[23];
						state_q   <= ST_DIV;
					end
				end
				ST_DIV: begin
					if (rem_sh_w >= {1'b0, den_q}) begin
						rem_q <= DEN_W'(rem_sh_w - {1'b0, den_q});
						num_q <= {num_q[NUM_W-2:0], 1'b1};
					end else begin
						rem_q <= rem_sh_w[DEN_W-1:0];
						num_q <= {num_q[NUM_W-2:0], 1'b0};
					end
					bit_cnt_q <= bit_cnt_q - 1'b1;
					if (bit_cnt_q == CNT_W'(1)) begin
						state_q <= ST_FILTER_SELECT;
					end
				end
				ST_FILTER_SELECT: begin
					state_q <= ST_OUT;
				end
				ST_OUT: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
			if (state_q == ST_FILTER_SELECT) begin
				// saturate instead of wrapping on overload
				if (|num_q[NUM_W-1:31]) begin
					abs_val_q <= neg_q ? -32'sh7fffffff : 32'sh7fffffff;
				end else begin
					abs_val_q <= neg_q ? -$signed({1'b0, num_q[30:0]})
						: $signed({1'b0, num_q[30:0]});
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= (state_q == ST_IDLE) ? (sample_valid && den_w != '0)
				: (state_q != ST_OUT);
		end
	end

	// ======================================================================
	// millisecond tick shared by dynamic control and settle timer
	logic [MS_W-1:0] ms_cnt_q;
	logic            ms_tick_q;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ms_cnt_q  <= '0;
			ms_tick_q <= 1'b0;
		end else begin
			ms_tick_q <= (ms_cnt_q == MS_W'(MS_CYCLES - 1));
			ms_cnt_q  <= (ms_cnt_q == MS_W'(MS_CYCLES - 1)) ? '0 : ms_cnt_q + 1'b1;
		end
	end

	// ======================================================================
	// dynamic IIR level control
	logic               dyn_mode_w;
	logic               fixed_iir_w;
	logic [15:0]        period_cnt_q;
	logic signed [31:0] dyn_ref_q;
	logic signed [32:0] dyn_delta_w;
	logic [32:0]        dyn_delta_mag_w;
	logic               eval_w;

	assign dyn_mode_w  = (filter_select_q == FSEL_DYNAMIC);
	assign fixed_iir_w = (filter_select_q >= FSEL_IIR1) && (filter_select_q <= FSEL_IIR8);
	assign dyn_delta_w = 33'(abs_val_q) - 33'(dyn_ref_q);
	assign dyn_delta_mag_w = dyn_delta_w[32] ? 33'(-dyn_delta_w) : 33'(dyn_delta_w);
	// a period of 0 behaves as 1 ms
	assign eval_w = ms_tick_q && (period_cnt_q + 16'h0001 >= dyn_filter_period_q);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			period_cnt_q <= '0;
			dyn_ref_q    <= 32'sh0;
			iir_level_q  <= IIR_LEVEL_MIN;
		end else if (fixed_iir_w) begin
			iir_level_q  <= 4'(filter_select_q - FSEL_IIR1) + IIR_LEVEL_MIN;
			period_cnt_q <= '0;
		end else if (dyn_mode_w) begin
			if (eval_w) begin
				period_cnt_q <= '0;
				dyn_ref_q    <= abs_val_q;
				if (dyn_delta_mag_w > 33'(dyn_filter_limit_q)) begin
					if (iir_level_q > IIR_LEVEL_MIN) begin
						iir_level_q <= iir_level_q - 1'b1;
					end
				end else if (iir_level_q < IIR_LEVEL_MAX) begin
					iir_level_q <= iir_level_q + 1'b1;
				end
			end else if (ms_tick_q) begin
				period_cnt_q <= period_cnt_q + 1'b1;
			end
		end else begin
			period_cnt_q <= '0;
		end
	end

	// ======================================================================
	// filters: IIR y += (x - y) >>> level, FIR boxcar notch
	logic signed [31:0] iir_q;
	logic               primed_q;
	logic signed [32:0] iir_step_w;
	logic signed [31:0] fir_mem [FIR_DEPTH];
	logic [PTR_W-1:0]   fir_ptr_q;
	logic [PTR_W:0]     fir_fill_q;
	logic signed [47:0] fir_sum_q;
	logic [PTR_W:0]     taps_w;
	logic [RECIP_BITS:0] recip_w;
	logic signed [47:0] fir_sum_d;
	logic signed [31:0] fir_old_w;
	logic               fir_mode_w;
	logic signed [65:0] fir_avg_w;
	logic signed [31:0] filter_select_w;

	assign fir_mode_w = (filter_select_q == FSEL_FIR50) || (filter_select_q == FSEL_FIR60);
	assign taps_w  = (filter_select_q == FSEL_FIR50) ? (PTR_W+1)'(FIR50_TAPS)
		: (PTR_W+1)'(FIR60_TAPS);
	assign recip_w = (filter_select_q == FSEL_FIR50) ? RECIP50 : RECIP60;
	// until the ring has filled, stale entries must not leave the sum
	assign fir_old_w  = (fir_fill_q >= taps_w) ? fir_mem[fir_ptr_q] : 32'sh0;
	assign fir_sum_d  = fir_sum_q + 48'(abs_val_q) - 48'(fir_old_w);
	assign fir_avg_w  = 66'(fir_sum_d) * $signed({1'b0, recip_w});
	assign iir_step_w = (33'(abs_val_q) - 33'(iir_q)) >>> iir_level_q;

	always_comb begin
		if (dyn_mode_w || fixed_iir_w) begin
			filter_select_w = primed_q ? 32'(33'(iir_q) + iir_step_w) : abs_val_q;
		end else if (fir_mode_w) begin
			filter_select_w = 32'(fir_avg_w >>> RECIP_BITS);
		end else begin
			filter_select_w = abs_val_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b || fsel_wr_q) begin
			iir_q      <= 32'sh0;
			primed_q   <= 1'b0;
			fir_ptr_q  <= '0;
			fir_fill_q <= '0;
			fir_sum_q  <= 48'sh0;
		end else if (state_q == ST_OUT) begin
			iir_q    <= filter_select_w;
			primed_q <= 1'b1;
			if (fir_mode_w) begin
				fir_sum_q <= fir_sum_d;
				fir_ptr_q <= (fir_ptr_q == PTR_W'(taps_w - 1'b1)) ? '0 : fir_ptr_q + 1'b1;
				if (fir_fill_q < taps_w) begin
					fir_fill_q <= fir_fill_q + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (state_q == ST_OUT && fir_mode_w) begin
			fir_mem[fir_ptr_q] <= abs_val_q;
		end
	end

	// ======================================================================
	// gain and tare, both at 2^-12
	logic signed [48:0] scaled_w;

	assign scaled_w = 49'(filter_select_w) * $signed({1'b0, user_gain_q})
		+ 49'($signed(user_tare_q));

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			weight_q       <= 32'sh0;
			weight_valid_q <= 1'b0;
		end else begin
			weight_valid_q <= (state_q == ST_OUT);
			if (state_q == ST_OUT) begin
				weight_q <= 32'(scaled_w >>> FRAC_BITS);
			end
		end
	end

	// ======================================================================
	// steady state: filtered value held inside +/- tolerance of an anchor
	logic signed [31:0] anchor_q;
	logic [16:0]        settle_ms_q;
	logic signed [32:0] dev_w;
	logic [32:0]        dev_mag_w;
	logic               outside_w;

	assign dev_w     = 33'(filter_select_w) - 33'(anchor_q);
	assign dev_mag_w = dev_w[32] ? 33'(-dev_w) : 33'(dev_w);
	assign outside_w = (state_q == ST_OUT) && (dev_mag_w > 33'(settle_tolerance_q));

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			anchor_q            <= 32'sh0;
			settle_ms_q         <= '0;
			weigh_status_word_q <= 16'h0000;
		end else if (outside_w) begin
			anchor_q    <= filter_select_w;
			settle_ms_q <= '0;
			weigh_status_word_q[STAT_STEADY_BIT] <= 1'b0;
		end else begin
			// counter stops one past the limit, enough to hold the bit
			if (ms_tick_q && settle_ms_q <= {1'b0, settle_time_q}) begin
				settle_ms_q <= settle_ms_q + 1'b1;
			end
			if (settle_ms_q > {1'b0, settle_time_q}) begin
				weigh_status_word_q[STAT_STEADY_BIT] <= 1'b1;
			end
		end
	end
endmodule

// >>> design/wfs_pkg.sv
/*
 * constants, parameter codes and reset values for the weighing post-processor.
 * assumes one 100 MHz clock shared with the bridge converter that feeds it.
 */
package wfs_pkg;
	// ======================================================================
	// parameter indices on the write port
	localparam logic [7:0]  IDX_FILTER_SELECT  = 8'h05;
	localparam logic [7:0]  IDX_DYN_PERIOD     = 8'h06;
	localparam logic [7:0]  IDX_DYN_LIMIT      = 8'h07;
	localparam logic [7:0]  IDX_SENSITIVITY    = 8'h08;
	localparam logic [7:0]  IDX_ZERO_OFFSET    = 8'h09;
	localparam logic [7:0]  IDX_USER_GAIN      = 8'h0a;
	localparam logic [7:0]  IDX_USER_TARE      = 8'h0b;
	localparam logic [7:0]  IDX_FULL_LOAD      = 8'h0c;
	localparam logic [7:0]  IDX_LOAD_SCALING   = 8'h0d;
	localparam logic [7:0]  IDX_SETTLE_TOL     = 8'h0e;
	localparam logic [7:0]  IDX_SETTLE_TIME    = 8'h0f;
	// ======================================================================
	// reset values
	localparam logic [7:0]  RST_FILTER_SELECT  = 8'h00;
	localparam logic [15:0] RST_DYN_PERIOD     = 16'h0010;
	localparam logic [15:0] RST_DYN_LIMIT      = 16'h0020;
	localparam logic [15:0] RST_SENSITIVITY    = 16'h4e20;
	localparam logic [15:0] RST_ZERO_OFFSET    = 16'h0000;
	localparam logic [15:0] RST_USER_GAIN      = 16'h1000;
	localparam logic [15:0] RST_USER_TARE      = 16'h0000;
	localparam logic [15:0] RST_FULL_LOAD      = 16'h0002;
	localparam logic [15:0] RST_LOAD_SCALING   = 16'h03e8;
	localparam logic [15:0] RST_SETTLE_TOL     = 16'h0005;
	localparam logic [15:0] RST_SETTLE_TIME    = 16'h03e8;
	// ======================================================================
	// filter_select codes
	localparam logic [7:0]  FSEL_OFF           = 8'h00;
	localparam logic [7:0]  FSEL_DYNAMIC       = 8'h01;
	localparam logic [7:0]  FSEL_IIR1          = 8'h02;
	localparam logic [7:0]  FSEL_IIR8          = 8'h09;
	localparam logic [7:0]  FSEL_FIR50         = 8'h0a;
	localparam logic [7:0]  FSEL_FIR60         = 8'h0b;
	localparam logic [3:0]  IIR_LEVEL_MIN      = 4'h1;
	localparam logic [3:0]  IIR_LEVEL_MAX      = 4'h8;
	// ======================================================================
	// scaling and timing
	localparam logic [3:0]  STAT_STEADY_BIT    = 4'h1;
	localparam int          FRAC_BITS          = 12;
	localparam int          RATIO_E7           = 10000000;
	localparam int          CLK_PERIOD_NS      = 10;
	localparam int          MS_NS              = 1000000;
	localparam int          MS_CYCLES_DOC      = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          FIR50_TAPS_DEF     = 20;
	localparam int          FIR60_TAPS_DEF     = 16;
	localparam int          RECIP_BITS         = 16;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DIV  = 2'b01,
		ST_FILTER_SELECT = 2'b10,
		ST_OUT  = 2'b11
	} wfs_state_t;
endpackage

// >>> tb/wfs_properties.sv
/*
 * concurrent checks on the ports of the weighing post-processor.
 * assumes one clock domain and the design package constants.
 */
`timescale 1ns/1ns
module wfs_properties
	import wfs_pkg::*;
#(
	parameter int MS_CYCLES = 10
) (
	input wire logic               clk,
	input wire logic               rst_b,
	input wire logic               param_wr,
	input wire logic [7:0]         param_idx,
	input wire logic [15:0]        param_data,
	input wire logic               sample_valid,
	input wire logic signed [23:0] bridge_sense_voltage,
	input wire logic signed [31:0] weight_q,
	input wire logic               weight_valid_q,
	input wire logic [15:0]        weigh_status_word_q,
	input wire logic [3:0]         iir_level_q,
	input wire logic               busy_q
);
	// ======================================================================
	// mode tracking
	logic [7:0]  mode_q;
	logic [1:0]  held_q;
	logic [3:0]  lvl_q;
	logic [31:0] gap_q;
	logic        seen_q;
	logic        fixed;
	logic        dyn;
	logic        moved;
	assign fixed = mode_q >= FSEL_IIR1 && mode_q <= FSEL_IIR8 && held_q == 2'h3;
	assign dyn = mode_q == FSEL_DYNAMIC && held_q == 2'h3;
	assign moved = iir_level_q != lvl_q;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mode_q <= FSEL_OFF;
			held_q <= 2'h0;
		end else if (param_wr && param_idx == IDX_FILTER_SELECT) begin
			mode_q <= param_data[7:0];
			held_q <= 2'h0;
		end else if (held_q != 2'h3) begin
			held_q <= held_q + 2'h1;
		end
	end
	// only gaps between two moves inside dynamic mode count, ticks run free
	always_ff @(posedge clk) begin
		lvl_q <= iir_level_q;
		if (!rst_b || !dyn) begin
			gap_q <= 32'h0;
			seen_q <= 1'b0;
		end else if (moved) begin
			gap_q <= 32'h0;
			seen_q <= 1'b1;
		end else begin
			gap_q <= gap_q + 32'h1;
		end
	end
	// ======================================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_valid_pulse: assert property (weight_valid_q |=> !weight_valid_q)
		else $error("result valid longer than one cycle");
	a_result_latency: assert property ($rose(busy_q) |-> ##[80:88] weight_valid_q)
		else $error("result not delivered in time");
	a_result_hold: assert property (!weight_valid_q |-> $stable(weight_q))
		else $error("weight changed without valid");
	a_zero_dropped: assert property (sample_valid && !busy_q && bridge_sense_voltage == 24'sh0
		|=> !busy_q)
		else $error("zero sense sample was taken");
	a_status_bits: assert property (weigh_status_word_q[15:2] == 14'h0
		&& !weigh_status_word_q[0])
		else $error("status bit other than steady set");
	a_level_range: assert property (iir_level_q >= IIR_LEVEL_MIN
		&& iir_level_q <= IIR_LEVEL_MAX)
		else $error("filter level out of range");
	a_fixed_level: assert property (fixed && weight_valid_q
		|-> iir_level_q == mode_q[3:0] - 4'h1)
		else $error("fixed filter level not kept");
	a_dyn_step: assert property (dyn && moved
		|-> iir_level_q == lvl_q + 4'h1 || iir_level_q == lvl_q - 4'h1)
		else $error("dynamic level jumped more than one step");
	a_dyn_period: assert property (dyn && moved && seen_q |-> gap_q >= MS_CYCLES - 1)
		else $error("dynamic level moved before period ended");
endmodule
bind wfs_top wfs_properties #(.MS_CYCLES(MS_CYCLES)) u_props (
	.clk(clk), .rst_b(rst_b), .param_wr(param_wr), .param_idx(param_idx),
	.param_data(param_data), .sample_valid(sample_valid),
	.bridge_sense_voltage(bridge_sense_voltage), .weight_q(weight_q),
	.weight_valid_q(weight_valid_q), .weigh_status_word_q(weigh_status_word_q),
	.iir_level_q(iir_level_q), .busy_q(busy_q)
);

// >>> tb/wfs_bridge_model.sv
/*
 * bridge converter front end: hands signal and sense samples as pairs.
 * assumes the bench calls send and the block reports busy_q.
 */
`timescale 1ns/1ns
module wfs_bridge_model (
	input wire logic          clk,
	input wire logic          busy_q,
	output logic              sample_valid,
	output logic signed [23:0] bridge_signal_voltage,
	output logic signed [23:0] bridge_sense_voltage
);
	initial begin
		sample_valid = 1'b0;
		bridge_signal_voltage = 24'sh0;
		bridge_sense_voltage = 24'sh0;
	end
	// lag makes a slow converter; data is inverted after the strobe
	task automatic send(input logic signed [23:0] sig, input logic signed [23:0] sen,
		input int lag);
		repeat (lag) @(posedge clk);
		@(posedge clk);
		#1;
		while (busy_q) begin
			@(posedge clk);
			#1;
		end
		sample_valid = 1'b1;
		bridge_signal_voltage = sig;
		bridge_sense_voltage = sen;
		@(posedge clk);
		#1;
		sample_valid = 1'b0;
		bridge_signal_voltage = ~sig;
		bridge_sense_voltage = ~sen;
	endtask
endmodule

// >>> tb/tb.sv
/*
 * self-checking bench for the weighing post-processor.
 * assumes a 1 ms tick shortened to 10 clocks.
 */
`timescale 1ns/1ns
module tb;
	import wfs_pkg::*;
	logic               clk;
	logic               rst_b;
	logic               param_wr;
	logic [7:0]         param_idx;
	logic [15:0]        param_data;
	logic               sample_valid;
	logic signed [23:0] sig;
	logic signed [23:0] sen;
	logic signed [31:0] weight_q;
	logic               weight_valid_q;
	logic [15:0]        stat;
	logic [3:0]         lvl;
	logic               busy_q;
	logic signed [31:0] w;
	int                 mismatches;
	int                 tests_run;
	wfs_top #(.MS_CYCLES(10)) dut (.clk(clk), .rst_b(rst_b), .param_wr(param_wr),
		.param_idx(param_idx), .param_data(param_data), .sample_valid(sample_valid),
		.bridge_signal_voltage(sig), .bridge_sense_voltage(sen), .weight_q(weight_q),
		.weight_valid_q(weight_valid_q), .weigh_status_word_q(stat), .iir_level_q(lvl),
		.busy_q(busy_q));
	wfs_bridge_model bm (.clk(clk), .busy_q(busy_q), .sample_valid(sample_valid),
		.bridge_signal_voltage(sig), .bridge_sense_voltage(sen));
	// ======================================================================
	// common tasks
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		if (mismatches == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic do_reset(input int n);
		@(posedge clk);
		#1;
		rst_b = 1'b0;
		repeat (n) @(posedge clk);
		#1;
		rst_b = 1'b1;
		check("reset weight", 32'h0, weight_q);
		check("reset valid", 32'h0, {31'h0, weight_valid_q});
		check("reset status", 32'h0, {16'h0, stat});
	endtask
	task automatic wr(input logic [7:0] idx, input logic [15:0] data);
		@(posedge clk);
		#1;
		param_wr = 1'b1;
		param_idx = idx;
		param_data = data;
		@(posedge clk);
		#1;
		param_wr = 1'b0;
	endtask
	task automatic run(input logic signed [23:0] s, input int lag);
		int n;
		n = 0;
		bm.send(s, 24'sh3e8, lag);
		while (weight_valid_q !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("result valid", 32'h1, {31'h0, weight_valid_q});
		check("busy after result", 32'h0, {31'h0, busy_q});
		w = weight_q;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// ======================================================================
	// scenarios
	task automatic t_scale();
		do_reset(2);
		check("reset level", {28'h0, IIR_LEVEL_MIN}, {28'h0, lvl});
		run(24'sh2, 0);
		check("default scale", 32'h7d0, w);
		run(-24'sh2, 0);
		check("negative scale", -32'sh7d0, w);
		wr(IDX_SENSITIVITY, 16'h2710);
		run(24'sh2, 0);
		check("sensitivity", 32'hfa0, w);
		wr(IDX_FULL_LOAD, 16'h0003);
		run(24'sh2, 0);
		check("full load", 32'h1770, w);
		wr(IDX_LOAD_SCALING, 16'h0001);
		run(24'sh2, 0);
		check("load scaling", 32'h6, w);
	endtask
	task automatic t_zero();
		int cnt;
		cnt = 0;
		do_reset(2);
		wr(IDX_ZERO_OFFSET, 16'h2710);
		run(24'sh4, 0);
		// 4 mV/V less 1 mV/V zero, over 2 mV/V, times 2 * 1000
		check("zero balance", 32'hbb8, w);
		bm.send(24'sh2, 24'sh0, 0);
		repeat (100) begin
			@(posedge clk);
			#1;
			cnt += int'(weight_valid_q === 1'b1);
		end
		check("dropped sample", 32'h0, cnt);
	endtask
	task automatic t_gain();
		do_reset(2);
		wr(IDX_USER_GAIN, 16'h2000);
		run(24'sh2, 0);
		check("gain", 32'hfa0, w);
		wr(IDX_USER_TARE, 16'h1000);
		run(24'sh2, 0);
		check("tare up", 32'hfa1, w);
		wr(IDX_USER_TARE, 16'hf000);
		run(24'sh2, 0);
		check("tare down", 32'hf9f, w);
		wr(IDX_USER_TARE, 16'h0000);
		wr(IDX_USER_GAIN, 16'h0800);
		run(24'sh2, 0);
		check("half gain", 32'h3e8, w);
	endtask
	task automatic t_filter();
		logic [7:0]  codes [4] = '{8'h00, 8'h0a, 8'h0b, 8'hff};
		logic [31:0] exps [4] = '{32'h7d0, 32'h63, 32'h7d, 32'h7d0};
		do_reset(2);
		for (int c = 2; c <= 9; c++) begin
			wr(IDX_FILTER_SELECT, 16'(c));
			run(24'sh2, 0);
			run(24'sh6, 0);
			check("iir output", 32'h7d0 + (32'hfa0 >> (c - 1)), w);
			check("iir level", 32'(c - 1), {28'h0, lvl});
		end
		for (int i = 0; i < 4; i++) begin
			wr(IDX_FILTER_SELECT, {8'h00, codes[i]});
			run(24'sh2, 0);
			check("other filter", exps[i], w);
		end
	endtask
	task automatic t_dyn();
		do_reset(2);
		wr(IDX_FILTER_SELECT, 16'h0001);
		wr(IDX_DYN_PERIOD, 16'h0001);
		repeat (12) run(24'sh2, 0);
		check("dynamic settled", {28'h0, IIR_LEVEL_MAX}, {28'h0, lvl});
		// spacing above the period so most evaluations see one change
		wr(IDX_DYN_PERIOD, 16'h0009);
		for (int i = 0; i < 20; i++)
			run(i[0] ? 24'sh14 : 24'sh2, 15);
		check("dynamic weakened", 32'h1, {31'h0, lvl <= 4'h2});
		wr(IDX_DYN_LIMIT, 16'hffff);
		for (int i = 0; i < 20; i++)
			run(i[0] ? 24'sh14 : 24'sh2, 15);
		check("limit not reached", {28'h0, IIR_LEVEL_MAX}, {28'h0, lvl});
	endtask
	task automatic t_steady();
		do_reset(2);
		wr(IDX_LOAD_SCALING, 16'h0001);
		wr(IDX_SETTLE_TIME, 16'h0003);
		run(24'sh14, 0);
		run(24'sh2, 0);
		check("steady after jump", 32'h0, {31'h0, stat[1]});
		run(24'sh2, 0);
		check("steady set", 32'h1, {31'h0, stat[1]});
		run(24'sh6, 0);
		check("inside tolerance", 32'h1, {31'h0, stat[1]});
		run(24'shc, 0);
		check("outside tolerance", 32'h0, {31'h0, stat[1]});
		wr(IDX_SETTLE_TIME, 16'h00c8);
		run(24'shc, 0);
		run(24'shc, 0);
		check("long window", 32'h0, {31'h0, stat[1]});
	endtask
	// ======================================================================
	// sequence
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		rst_b = 1'b0;
		param_wr = 1'b0;
		param_idx = 8'h00;
		param_data = 16'h0000;
		mismatches = 0;
		tests_run = 0;
		repeat (10) @(posedge clk);
		#1;
		rst_b = 1'b1;
		t_scale();
		t_zero();
		t_gain();
		t_filter();
		t_dyn();
		t_steady();
		summarize();
	end
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		summarize();
	end
endmodule
